// *** logic/ifsb_bank.sv ***
// interrupt flag bank with axi4-lite register slave and one irq line
// assumes: source requests are one-clock pulses or levels on clk
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ifsb_defines.svh"
module ifsb_bank
  import ifsb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire ifsb_flags_t src_req,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic        service_req,
  output var  logic        irq
);
  ifsb_flags_t  flags;
  logic [15:0]  enables0;
  logic [4:0]   status;
  logic [4:0]   mask;
  logic [15:0]  wmask16;
  logic [15:0]  wval16;
  logic [11:0]  aw_addr;
  logic         aw_have;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         w_have;
  logic         do_write;
  logic [4:0]   ev;
  logic [15:0]  gate0;

  logic [11:0]  next_aw_addr;
  logic         next_aw_have;
  logic [31:0]  next_w_data;
  logic [3:0]   next_w_strb;
  logic         next_w_have;
  logic         next_bvalid;
  logic [1:0]   next_bresp;
  logic         next_rvalid;
  logic [31:0]  next_rdata;
  logic [1:0]   next_rresp;
  logic [15:0]  next_enables0;
  logic [4:0]   next_status;
  logic [4:0]   next_mask;
  logic         next_service;
  logic         next_irq;
  logic         next_awready;
  logic         next_wready;
  logic         next_arready;

  localparam logic [15:0] IMPL [5] = '{`IFSB_MASK_FLAGS0, `IFSB_MASK_FLAGS1,
    `IFSB_MASK_FLAGS2, `IFSB_MASK_FLAGS3, `IFSB_MASK_FLAGS4};
  localparam logic [11:0] OFFS [5] = '{`IFSB_OFF_FLAGS0, `IFSB_OFF_FLAGS1,
    `IFSB_OFF_FLAGS2, `IFSB_OFF_FLAGS3, `IFSB_OFF_FLAGS4};

  logic [15:0] fq   [5];
  logic [15:0] fset [5];

  assign fset[0] = src_req.f0;
  assign fset[1] = src_req.f1;
  assign fset[2] = src_req.f2;
  assign fset[3] = src_req.f3;
  assign fset[4] = src_req.f4;
  assign flags = '{f0: fq[0], f1: fq[1], f2: fq[2], f3: fq[3], f4: fq[4]};

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  // byte strobes merge new data into the old register word
  assign wmask16  = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wval16   = w_data[15:0];

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_flag
      logic fw;
      assign fw = do_write && (aw_addr == OFFS[gi]);
      // R2 R3 R4 R5 R6 R7 bit map
      ifsb_flag_reg #(
        .IMPL (IMPL[gi])
      ) u_reg (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (fset[gi] & IMPL[gi]),
        .wr    (fw),
        .wdata ((fq[gi] & ~wmask16) | (wval16 & wmask16)),
        .q     (fq[gi])
      );
      assign ev[gi] = |(fset[gi] & IMPL[gi]);
    end
  endgenerate

  // write channel: address and data are taken in either order
  always_comb
  begin
    next_aw_addr  = aw_addr;
    next_aw_have  = aw_have;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_w_have   = w_have;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_addr = {s_axi_awaddr[11:2], 2'b00};
      next_aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_have = 1'b1;
    end
    if (do_write)
    begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      // unmapped words answer with a slave error and change nothing
      next_bresp   = 2'b10;
      unique case (aw_addr)
        `IFSB_OFF_FLAGS0, `IFSB_OFF_FLAGS1, `IFSB_OFF_FLAGS2,
        `IFSB_OFF_FLAGS3, `IFSB_OFF_FLAGS4, `IFSB_OFF_ENABLES0,
        `IFSB_OFF_STATUS, `IFSB_OFF_MASK:
          next_bresp = 2'b00;
        default: ;
      endcase
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    // readies stay low while a word is held or the answer waits
    next_awready = !next_aw_have && !next_bvalid;
    next_wready  = !next_w_have && !next_bvalid;
  end

  // software-visible registers, written once both halves are in
  always_comb
  begin
    next_enables0 = enables0;
    next_mask     = mask;
    next_status   = status;
    if (do_write)
    begin
      unique case (aw_addr)
        // R8 R9 enable layout
        `IFSB_OFF_ENABLES0:
          next_enables0 = ((enables0 & ~wmask16) | (wval16 & wmask16))
                          & `IFSB_MASK_ENABLES0;
        `IFSB_OFF_STATUS:
          if (w_strb[0])
            next_status = status & ~w_data[4:0];
        `IFSB_OFF_MASK:
          if (w_strb[0])
            next_mask = w_data[4:0];
        default: ;
      endcase
    end
    // event sets win over a write-one clear
    next_status = next_status | ev;
  end

  // read channel
  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      next_rdata  = 32'h0000_0000;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `IFSB_OFF_FLAGS0:   next_rdata[15:0] = fq[0];
        `IFSB_OFF_FLAGS1:   next_rdata[15:0] = fq[1];
        `IFSB_OFF_FLAGS2:   next_rdata[15:0] = fq[2];
        `IFSB_OFF_FLAGS3:   next_rdata[15:0] = fq[3];
        `IFSB_OFF_FLAGS4:   next_rdata[15:0] = fq[4];
        `IFSB_OFF_ENABLES0: next_rdata[15:0] = enables0;
        `IFSB_OFF_STATUS:   next_rdata[4:0]  = status;
        `IFSB_OFF_MASK:     next_rdata[4:0]  = mask;
        default:            next_rresp       = 2'b10;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    next_arready = !next_rvalid;
  end

  // R10 each enable bit gates the flag in the same position
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_gate
      assign gate0[gi] = flags.f0[gi] && enables0[gi];
    end
  endgenerate

  always_comb
  begin
    next_service = |gate0;
    next_irq     = |(status & mask);
  end

  // write channel state
  // readies come from flops, so they are low during reset and rise
  // on the first edge after it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_addr       <= 12'h000;
      aw_have       <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      w_have        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      aw_addr       <= next_aw_addr;
      aw_have       <= next_aw_have;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_have        <= next_w_have;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // read channel state
  // rdata loads only on the address handshake, so it stands while
  // rvalid waits for rready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // software-visible registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // R11 zero at reset
      enables0 <= `IFSB_RESET_REG;
      status   <= 5'h00;
      mask     <= 5'h00;
    end
    else
    begin
      enables0 <= next_enables0;
      status   <= next_status;
      mask     <= next_mask;
    end
  end

  // request outputs lag by one edge: service_req the enabled flags, irq the masked status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      service_req <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      service_req <= next_service;
      irq         <= next_irq;
    end
  end
endmodule : ifsb_bank
`default_nettype wire

// *** logic/ifsb_defines.svh ***
// interrupt flag status bank: offsets, field masks, reset values
// assumes: included by bare name from logic/ and verif/ sources
// Behaviour
// R1: a flag bit reads 1 once its source has requested and 0 until then.
// R2: flags0 bit 2 is compare 1, bit 1 capture 1, bit 0 external irq 0.
// R3: flags1 bits 15..8 are uart2 tx, uart2 rx, ext2, timer5, timer4, cmp4, cmp3, dma2.
// R4: flags1 bits 7..0 are cap8, cap7, adc2, ext1, pin change, none, i2c1 master, i2c1 slave.
// R5: flags2 from bit 15 holds timer6, dma4, none, cmp8..5, cap6..3, dma3, can1 ev, can1 rx, spi2, spi2 err.
// R6: flags3 holds dma5 at 13, can2 event at 8, and bits 7..0 can2 rx, ext4, ext3, t9, t8, i2c2 m, i2c2 s, t7.
// R7: flags4 holds only bits 7..0: can2 tx, can1 tx, dma7, dma6, none, uart2 err, uart1 err, none.
// R8: enables0 bit 15 is absent and bits 14..0 enable dma1 down to external irq 0.
// R9: every absent bit ignores writes and reads zero.
// R10: an enable bit at 1 lets its matching flag request service, at 0 blocks it. Here it gates service_req only; irq follows status and mask.
// R11: present bits are read/write, zero at reset, and software clears a flag by writing 0.
`ifndef IFSB_DEFINES_SVH
`define IFSB_DEFINES_SVH

`define IFSB_OFF_FLAGS0    12'h000
`define IFSB_OFF_FLAGS1    12'h004
`define IFSB_OFF_FLAGS2    12'h008
`define IFSB_OFF_FLAGS3    12'h00c
`define IFSB_OFF_FLAGS4    12'h010
`define IFSB_OFF_ENABLES0  12'h014
`define IFSB_OFF_STATUS    12'h018
`define IFSB_OFF_MASK      12'h01c

// implemented-bit masks; flags0 only carries its low three bits here
`define IFSB_MASK_FLAGS0   16'h0007
`define IFSB_MASK_FLAGS1   16'hfffb
`define IFSB_MASK_FLAGS2   16'hdfff
`define IFSB_MASK_FLAGS3   16'h21ff
`define IFSB_MASK_FLAGS4   16'h00f6
`define IFSB_MASK_ENABLES0 16'h7fff
`define IFSB_MASK_STATUS   16'h001f

`define IFSB_RESET_REG     16'h0000

`endif

// *** logic/ifsb_flag_reg.sv ***
// one 16-bit flag register with hardware set and software write
// assumes: set pulses are synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module ifsb_flag_reg #(
  parameter logic [15:0] IMPL = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] set,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  output var  logic [15:0] q
);
  logic [15:0] next_q;

  always_comb
  begin
    next_q = q;
    // R11 software write
    if (wr)
      next_q = wdata;
    // R1 set beats clear
    next_q = next_q | set;
    // R9 absent bits zero
    next_q = next_q & IMPL;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= 16'h0000;
    else
      q <= next_q;
  end
endmodule : ifsb_flag_reg
`default_nettype wire

// *** logic/ifsb_pkg.sv ***
// interrupt flag status bank: shared types
// assumes: compiled before the design modules
package ifsb_pkg;
  typedef struct packed {
    logic [15:0] f0;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [15:0] f3;
    logic [15:0] f4;
  } ifsb_flags_t;

  typedef enum logic [1:0] {
    IFSB_W_IDLE = 2'b00,
    IFSB_W_RESP = 2'b01
  } ifsb_wstate_t;
endpackage : ifsb_pkg

// *** verif/ifsb_bank_asserts.sv ***
// checker: bus timing and irq outputs of the flag bank
// assumes: bound onto ifsb_bank, one clock domain
`timescale 1ns/1ns
`default_nettype none
module ifsb_bank_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        service_req,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_WR_LAT: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while bvalid");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata moved");
  AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  AST_RST: assert property ($rose(rst_n) |-> !service_req && !irq)
    else $error("request out of reset");
endmodule : ifsb_bank_asserts
bind ifsb_bank ifsb_bank_asserts u_chk (.clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .service_req, .irq);
`default_nettype wire

// *** verif/ifsb_src_model.sv ***
// peripheral sources: one request pulse per fired bit
// assumes: fire is driven for one clock on clk
`timescale 1ns/1ns
`default_nettype none
module ifsb_src_model
  import ifsb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire ifsb_flags_t fire,
  output var  ifsb_flags_t src_req
);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) src_req <= '0;
    else src_req <= fire;
endmodule : ifsb_src_model
`default_nettype wire

// *** verif/tb_ifsb_bank.sv ***
// bench: flag bank driven over axi4-lite, reads scored from a queue
// assumes: design, package and source model compiled first
`timescale 1ns/1ns
`default_nettype none
`include "ifsb_defines.svh"
module tb_ifsb_bank import ifsb_pkg::*;;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 1, rready = 1;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, srv, irq;
  ifsb_flags_t fire = '0, src_req;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  bresp, rresp, bq[$];
  logic [33:0] rq[$];
  logic [15:0] msk[6];
  int          err_count = 0, cmp_count = 0;
  always #25 clk = ~clk;
  ifsb_src_model i_src (.clk, .rst_n, .fire, .src_req);
  ifsb_bank i_dut (.clk, .rst_n, .src_req, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .service_req(srv), .irq);
  task chk(input string n, input logic [33:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task report_and_stop;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      ta |= awready;
      tw |= wready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!(ta && tw));
    do @(posedge clk); while (!bvalid);
  endtask : wr
  task rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
  endtask : rd
  task pulse(input ifsb_flags_t f);
    fire <= f;
    @(posedge clk);
    fire <= '0;
    repeat (4) @(posedge clk);
  endtask : pulse
  always @(posedge clk)
  begin
    if (rvalid && rready)
      chk("rd", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      chk("bresp", 34'(bresp), 34'(bq.pop_front()));
  end
  initial
  begin
    #2000000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    logic [31:0] d;
    void'($urandom(32'h1149));
    msk = '{`IFSB_MASK_FLAGS0, `IFSB_MASK_FLAGS1, `IFSB_MASK_FLAGS2,
      `IFSB_MASK_FLAGS3, `IFSB_MASK_FLAGS4, `IFSB_MASK_ENABLES0};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) rd(12'(i * 4), '0);
    pulse('1);
    for (int i = 0; i < 6; i++) rd(12'(i * 4), i < 5 ? 34'(msk[i]) : '0);
    rd(`IFSB_OFF_STATUS, 34'h1f);
    chk("irq", 34'(irq), 34'h0);
    wr(`IFSB_OFF_MASK, 32'h1f, 2'b00);
    repeat (2) @(posedge clk);
    chk("irq", 34'(irq), 34'h1);
    wr(`IFSB_OFF_STATUS, 32'h1f, 2'b00);
    repeat (2) @(posedge clk);
    chk("irq", 34'(irq), 34'h0);
    for (int i = 0; i < 6; i++)
    begin
      d = $urandom;
      wr(12'(i * 4), d, 2'b00);
      rd(12'(i * 4), 34'(d[15:0] & msk[i]));
      wr(12'(i * 4), '0, 2'b00);
      rd(12'(i * 4), '0);
    end
    // only the upper byte lane is written
    wstrb <= 4'h2;
    wr(`IFSB_OFF_ENABLES0, 32'hffff, 2'b00);
    wstrb <= 4'hf;
    rd(`IFSB_OFF_ENABLES0, 34'h7f00);
    wr(`IFSB_OFF_ENABLES0, 32'h1, 2'b00);
    pulse('{f0: 16'h0002, default: '0});
    chk("srv", 34'(srv), 34'h0);
    pulse('{f0: 16'h0001, default: '0});
    chk("srv", 34'(srv), 34'h1);
    chk("irq", 34'(irq), 34'h1);
    // second reset in mid-run must clear flags, enables and requests
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("srv", 34'(srv), 34'h0);
    chk("irq", 34'(irq), 34'h0);
    rd(`IFSB_OFF_FLAGS0, '0);
    rd(`IFSB_OFF_ENABLES0, '0);
    // answers held back so they must stand until taken
    rready <= 1'b0;
    bready <= 1'b0;
    rd(12'h020, {2'b10, 32'h0});
    wr(12'h020, '1, 2'b10);
    repeat (2) @(posedge clk);
    rready <= 1'b1;
    bready <= 1'b1;
    repeat (2) @(posedge clk);
    chk("left", 34'(rq.size() + bq.size()), 34'h0);
    report_and_stop();
  end
endmodule : tb_ifsb_bank
`default_nettype wire
